// ==== rps_pkg.sv ====
/*
  Package for the reset pin sequencer: state encoding, timing counts and
  the packed carriers for the reset domain outputs.
  Assumes a single 10 MHz system clock.
*/
package rps_pkg;

  // ****************************************
  // Timing
  // ****************************************
  // Cycles the soft reset pin is driven low per drive phase.
  localparam int unsigned DRIVE_CYCLES = 6;
  localparam logic [2:0] DRIVE_LAST = 3'h5;
  // Last of the sense cycles after a drive phase; only this one sees the
  // released line through both synchroniser stages.
  localparam logic [2:0] SENSE_LAST = 3'h2;
  // Last count of the power-on style reset sequence; its outputs stay asserted 16 cycles after the pin release is seen.
  localparam logic [3:0] POR_HOLD_LAST = 4'hF;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [3:0] POR_ZERO = 4'h0;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  // ****************************************
  // Types
  // ****************************************
  // One-hot states of the soft reset pin loop.
  typedef enum logic [3:0] {
    RPS_SENSE = 4'h1,
    RPS_DRIVE = 4'h2,
    RPS_PULSE = 4'h4,
    RPS_IDLE  = 4'h8
  } rps_state_t;

  // Reset requests to the rest of the chip, all active high.
  typedef struct packed {
    logic core;
    logic regs;
    logic periph;
    logic debug;
    logic por_regs;
  } rps_resets_t;

  // Drive value and output enable of a two-way pin.
  typedef struct packed {
    logic out;
    logic oe;
  } rps_pin_drv_t;

endpackage : rps_pkg

// ==== rps_sync.sv ====
/*
  Two flip-flop synchroniser for one pin level.
  Assumes the input is asynchronous to i_clk; reset value is the idle high level.
*/
`timescale 1ns/100ps
module rps_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Pin level
  input wire logic i_d,
  // Synchronised level
  output logic o_q
);

  logic [1:0] sync_reg;

  // Shift the pin level through two stages; only the second one is read.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync_reg <= 2'h3;
    end else begin
      sync_reg <= {sync_reg[0], i_d};
    end
  end

  assign o_q = sync_reg[1];

endmodule : rps_sync

// ==== rps_sequencer.sv ====
/*
  Reset pin sequencer: handles the hardware reset pin and the two-way
  soft reset pin, and produces the domain reset requests.
  Assumes both pins are asynchronous and pulled high externally, and that
  i_nrst is the chip power-on reset.
*/
`timescale 1ns/100ps
module rps_sequencer (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Reset pins
  input wire logic i_hw_reset_pin_n,
  input wire logic i_soft_reset_pin_n,
  output logic o_soft_reset_pin_n,
  output logic o_soft_reset_pin_oe,
  // Domain reset requests
  output rps_pkg::rps_resets_t o_resets,
  output logic o_rtc_reset,
  output logic o_start_exec
);

  // ****************************************
  // Synchronisers
  // ****************************************
  logic hw_n_sync;
  logic soft_n_sync;

  rps_sync u_sync_hw (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_d(i_hw_reset_pin_n),
    .o_q(hw_n_sync)
  );

  rps_sync u_sync_soft (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_d(i_soft_reset_pin_n),
    .o_q(soft_n_sync)
  );

  // ****************************************
  // Hardware reset sequence
  // ****************************************
  logic [3:0] por_cnt_reg;
  logic [3:0] por_cnt_next;
  logic hw_hold_reg;
  logic hw_active;
  logic por_running;

  // Pin low holds the count at zero; release lets the sequence run out.
  assign hw_active = !hw_n_sync;
  assign por_running = (por_cnt_reg != rps_pkg::POR_HOLD_LAST);
  assign por_cnt_next = hw_active ? rps_pkg::POR_ZERO :
                        (por_running ? por_cnt_reg + 4'h1 : por_cnt_reg);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      por_cnt_reg <= rps_pkg::POR_ZERO;
      hw_hold_reg <= 1'b1;
    end else begin
      por_cnt_reg <= por_cnt_next;
      hw_hold_reg <= hw_active || por_running;
    end
  end

  // ****************************************
  // Soft reset pin loop
  // ****************************************
  rps_pkg::rps_state_t state_reg;
  rps_pkg::rps_state_t state_next;
  logic [2:0] drv_cnt_reg;
  logic [2:0] drv_cnt_next;
  logic drive_done;
  logic sense_done;
  logic drv_cnt_run;
  logic loop_block;

  assign drive_done = (drv_cnt_reg == rps_pkg::DRIVE_LAST);
  // The line is judged only in the last sense cycle: in the first two the own drive is still in the
  // synchroniser, and judging it there would keep the loop running forever.
  assign sense_done = (drv_cnt_reg == rps_pkg::SENSE_LAST);
  // The loop is blocked from the first cycle the hardware pin is seen low, so no drive can start then.
  assign loop_block = hw_hold_reg || hw_active;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rps_pkg::RPS_IDLE: begin
        if (!soft_n_sync) begin
          state_next = rps_pkg::RPS_DRIVE;
        end
      end
      rps_pkg::RPS_DRIVE: begin
        if (drive_done) begin
          state_next = rps_pkg::RPS_SENSE;
        end
      end
      rps_pkg::RPS_SENSE: begin
        if (sense_done) begin
          state_next = soft_n_sync ? rps_pkg::RPS_PULSE : rps_pkg::RPS_DRIVE;
        end
      end
      rps_pkg::RPS_PULSE: begin
        state_next = rps_pkg::RPS_IDLE;
      end
      default: begin
        state_next = rps_pkg::RPS_IDLE;
      end
    endcase
  end

  // six drive cycles
  // The same counter times each drive phase and the sense wait after it.
  assign drv_cnt_run = (state_reg == rps_pkg::RPS_DRIVE && !drive_done) ||
                       (state_reg == rps_pkg::RPS_SENSE && !sense_done);
  assign drv_cnt_next = drv_cnt_run ? drv_cnt_reg + 3'h1 : rps_pkg::CNT_ZERO;

  // Hardware reset, from the first cycle its pin is seen low, keeps the loop idle.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= rps_pkg::RPS_IDLE;
      drv_cnt_reg <= rps_pkg::CNT_ZERO;
    end else if (loop_block) begin
      state_reg <= rps_pkg::RPS_IDLE;
      drv_cnt_reg <= rps_pkg::CNT_ZERO;
    end else begin
      state_reg <= state_next;
      drv_cnt_reg <= drv_cnt_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic soft_hold;
  logic pin_oe_reg;

  assign soft_hold = (state_reg != rps_pkg::RPS_IDLE);

  // Pin enable follows the drive state, registered so it matches the counter.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_oe_reg <= 1'b0;
    end else begin
      pin_oe_reg <= !loop_block && (state_next == rps_pkg::RPS_DRIVE);
    end
  end

  assign o_soft_reset_pin_oe = pin_oe_reg;
  assign o_soft_reset_pin_n = 1'b0; // Only ever drives low.

  assign o_resets.core = hw_hold_reg || soft_hold;
  assign o_resets.regs = hw_hold_reg || soft_hold;
  assign o_resets.periph = hw_hold_reg || soft_hold;
  assign o_resets.debug = hw_hold_reg;
  assign o_resets.por_regs = hw_hold_reg;
  assign o_rtc_reset = 1'b0; // RTC is never reset by these pins.
  assign o_start_exec = !hw_hold_reg && !soft_hold;

  // ****************************************
  // Assertions
  // ****************************************
  a_drive_six_cycles: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(o_soft_reset_pin_oe) && !hw_hold_reg |-> o_soft_reset_pin_oe[*6] ##1
      (!o_soft_reset_pin_oe || hw_hold_reg))
    else $error("Drive phase not six cycles");

  a_low_starts_drive: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_reg == rps_pkg::RPS_IDLE && !loop_block && !soft_n_sync |=> o_soft_reset_pin_oe)
    else $error("Low pin not answered by drive");

  a_sense_between: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $fell(o_soft_reset_pin_oe) && !hw_hold_reg |-> state_reg == rps_pkg::RPS_SENSE)
    else $error("Drive phase not followed by sense");

  a_sense_wait: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $fell(o_soft_reset_pin_oe) |-> !o_soft_reset_pin_oe[*3])
    else $error("Sense wait shorter than three cycles");

  a_high_ends_loop: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_reg == rps_pkg::RPS_SENSE && sense_done && soft_n_sync && !hw_hold_reg |=> ##1 !o_resets.core)
    else $error("High sense did not end soft reset");

  a_soft_hold_core: assert property (@(posedge i_clk) disable iff (!i_nrst)
    soft_hold |-> o_resets.core && o_resets.regs && o_resets.periph)
    else $error("Soft reset not held");

  a_soft_spares_debug: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !hw_hold_reg |-> !o_resets.debug && !o_resets.por_regs && !o_rtc_reset)
    else $error("Soft reset touched debug or POR logic");

  a_hw_holds_reset: assert property (@(posedge i_clk) disable iff (!i_nrst)
    hw_active |=> o_resets.por_regs && o_resets.debug && !o_start_exec)
    else $error("Hardware reset not held");

  a_release_resets: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_reg == rps_pkg::RPS_PULSE |-> o_resets.core && !o_start_exec)
    else $error("Release did not reset core");

  c_one_drive: cover property (@(posedge i_clk) disable iff (!i_nrst)
    state_reg == rps_pkg::RPS_SENSE ##1 state_reg == rps_pkg::RPS_PULSE);
  c_two_drives: cover property (@(posedge i_clk) disable iff (!i_nrst)
    state_reg == rps_pkg::RPS_SENSE ##1 state_reg == rps_pkg::RPS_DRIVE);
  c_hw_release: cover property (@(posedge i_clk) disable iff (!i_nrst) $fell(hw_hold_reg));
  c_hw_assert: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(hw_hold_reg));

endmodule : rps_sequencer

// ==== rps_ext_src.sv ====
/*
  External reset source model on the soft reset pin line.
  Assumes a pull-up on the line; the testbench decides when to pull low.
*/
`timescale 1ns/100ps
module rps_ext_src (
  // Controls
  input wire logic i_pull_low,
  // Device side of the pin
  input wire logic i_dev_oe,
  input wire logic i_dev_out,
  // Resolved line
  output logic o_line_n
);
  // Wire-AND of both drivers; a released line rises through the pull-up.
  assign o_line_n = !(i_pull_low || (i_dev_oe && !i_dev_out));
endmodule : rps_ext_src

// ==== testbench.sv ====
/*
  Self-checking testbench for the reset pin sequencer.
  Assumes rps_pkg, rps_sync, rps_sequencer and rps_ext_src compile first.
*/
`timescale 1ns/100ps
module testbench;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic hw_n = 1'b1;
  logic pull = 1'b0;
  logic line_n;
  logic pin_out;
  logic pin_oe;
  rps_pkg::rps_resets_t rst;
  logic rtc_rst;
  logic start;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  // ****************************************
  // Clock, design and line model
  // ****************************************
  // The clock toggles every half period of 50 ns.
  always #50 i_clk = ~i_clk;
  rps_sequencer i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_hw_reset_pin_n(hw_n), .i_soft_reset_pin_n(line_n),
    .o_soft_reset_pin_n(pin_out), .o_soft_reset_pin_oe(pin_oe), .o_resets(rst), .o_rtc_reset(rtc_rst),
    .o_start_exec(start));
  rps_ext_src i_ext (.i_pull_low(pull), .i_dev_oe(pin_oe), .i_dev_out(pin_out), .o_line_n(line_n));

  // ****************************************
  // Helpers
  // ****************************************
  // Compares one value and records any mismatch.
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then stops.
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Cuts a hang short well beyond the expected run length.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      print_verdict();
    end
  end

  // Waits a bounded time for execution to start, then checks all resets are off.
  task automatic wait_start();
    for (int n = 0; n < 60 && start !== 1'b1; n++) @(negedge i_clk);
    check({start, rst, rtc_rst}, {1'b1, 5'h00, 1'b0});
  endtask : wait_start

  // ****************************************
  // Scenarios
  // ****************************************
  // Hardware pin low holds every domain but the RTC and blocks the soft loop.
  task automatic t_hw();
    @(posedge i_clk);
    #10 hw_n = 1'b0;
    pull = 1'b1;
    repeat (8) @(negedge i_clk);
    check({start, rst, rtc_rst, pin_oe}, {1'b0, 5'h1F, 2'b00});
    @(posedge i_clk);
    #10 hw_n = 1'b1;
    pull = 1'b0;
    wait_start();
  endtask : t_hw

  // Soft pin pulled low for hold cycles; each drive phase is measured.
  task automatic t_soft(input int hold, input int min_ph);
    int run;
    int ph;
    run = 0;
    ph = 0;
    for (int n = 0; n < 300 && !(ph > 0 && start === 1'b1); n++) begin
      @(posedge i_clk);
      #10 pull = (n < hold);
      @(negedge i_clk);
      if (pin_oe === 1'b1) begin
        run++;
        // pin driven low, core held, debug kept
        check({pin_out, rst}, {1'b0, 5'h1C});
      end else if (run != 0) begin
        ph++;
        check(8'(run), 8'h06);
        run = 0;
      end
    end
    check({7'h00, ph >= min_ph}, 8'h01);
    wait_start();
  endtask : t_soft

  // ****************************************
  // Main sequence
  // ****************************************
  // Resets the design, then runs every scenario in turn.
  initial begin
    repeat (3) @(posedge i_clk);
    #10;
    check({start, rst, rtc_rst}, {1'b0, 5'h1F, 1'b0});
    i_nrst = 1'b1;
    wait_start();
    t_hw();
    t_soft(1, 1);
    t_soft(40, 2);
    print_verdict();
  end
endmodule : testbench
